// ---- logic/dps_pkg.sv ----
// constants for the dual level power-on sequencer
// Contract
// - below analog level before first recall: outputs off, defaults held, shadow zero, analog off.
// - first reaching analog level: recall shadow settings, then enable analog.
// - above analog level: normal operation from recalled configuration.
// - analog drop above digital level: keep settings, analog off, outputs off.
// - analog level regained without digital drop: resume at once, no recall.
// - below digital level: settings to defaults, new recall required.
// - after digital drop, recall at next rise above analog level.
// - host reads not-ready bit in status byte while above digital level.
// - not-ready set below analog level; cleared within 500 us after rise.
// - address from memory: answer at default address until recall done.
// - analog good asserts supply-low alarm; cleared by conversion above limit.
// - tx fault output does not latch until conversion above limit.
// - supply-low alarm from analog good cannot be masked.
package dps_pkg;
  localparam logic [7:0] DPS_STATUS_OFS = 8'h6E;
  localparam logic [7:0] DPS_ADDR_SRC_OFS = 8'h8C;
  localparam logic [7:0] DPS_DEFAULT_ADDR = 8'hA2;
  localparam int DPS_NRDY_BIT = 0;
  localparam int DPS_VLO_BIT = 1;
  localparam int DPS_TXF_BIT = 2;
  localparam int DPS_ADDR_FROM_NV_BIT = 0;
  localparam int DPS_CLK_MHZ = 40;
  localparam int DPS_NRDY_US = 500;
  localparam int DPS_RECALL_CYC = 4;
  localparam int DPS_SYNC_CYC = 3;
  localparam int DPS_NRDY_CYC = DPS_NRDY_US * DPS_CLK_MHZ;
  localparam int DPS_CNT_W = 15;
  typedef enum logic [1:0] {
    DPS_OFF, DPS_RECALL, DPS_RUN, DPS_HOLD
  } dps_state_t;
endpackage : dps_pkg

// ---- logic/dps_sync.sv ----
// two flip-flop synchroniser for one level
`timescale 1ns/10ps
module dps_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_d,
  output logic o_q
);
  typedef struct packed {
    logic s1;
    logic s2;
  } dps_sync_t;
  dps_sync_t st_r;
  dps_sync_t st_nxt;
  always_comb begin
    st_nxt.s1 = i_d;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign o_q = st_r.s2;
endmodule : dps_sync

// ---- logic/dps_sequencer.sv ----
// power-on sequencer core with status and address registers
`timescale 1ns/10ps
module dps_sequencer (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_dig_good,
  input wire logic i_ana_good,
  input wire logic i_vcc_conv_valid,
  input wire logic [15:0] i_vcc_conv,
  input wire logic [15:0] i_vcc_low_limit,
  input wire logic i_tx_fault_in,
  input wire logic i_clr_tx_fault,
  input wire logic [7:0] i_nv_addr_src,
  input wire logic [7:0] i_nv_addr,
  input wire logic i_recall_done,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_recall_req,
  output logic o_defaults,
  output logic o_analog_en,
  output logic o_out_en,
  output logic o_not_ready_flag,
  output logic o_supply_low_alarm,
  output logic o_tx_fault_output,
  output logic [7:0] o_bus_addr
);
  import dps_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers
  logic rst_s1_r;
  logic rst_n_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_q <= rst_s1_r;
    end
  end

  logic dig_good;
  logic ana_good;
  dps_sync u_sync_dig (
    .i_clk(i_clk),
    .i_rst_n(rst_n_q),
    .i_d(i_dig_good),
    .o_q(dig_good)
  );
  dps_sync u_sync_ana (
    .i_clk(i_clk),
    .i_rst_n(rst_n_q),
    .i_d(i_ana_good & i_dig_good),
    .o_q(ana_good)
  );

  // tx fault pin synchroniser
  logic tx_fault;
  dps_sync u_sync_txf (
    .i_clk(i_clk),
    .i_rst_n(rst_n_q),
    .i_d(i_tx_fault_in),
    .o_q(tx_fault)
  );

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    dps_state_t state;
    logic recall_needed;
    logic [DPS_CNT_W-1:0] cnt;
    logic nrdy;
    logic vlo;
    logic armed;
    logic txf;
    logic run;
    logic rcl;
    logic [7:0] addr_src;
    logic [7:0] addr;
    logic [7:0] rdata;
  } dps_seq_t;
  dps_seq_t st_r;
  dps_seq_t st_nxt;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  // not-ready release point
  function automatic logic nrdy_due(input logic [DPS_CNT_W-1:0] c);
    nrdy_due = (c >= DPS_CNT_W'(DPS_NRDY_CYC - DPS_SYNC_CYC - 1));
  endfunction : nrdy_due

  logic conv_above;
  assign conv_above = i_vcc_conv_valid && (i_vcc_conv > i_vcc_low_limit);

  always_comb begin
    st_nxt = st_r;
    if (!dig_good) begin
      st_nxt.state = DPS_OFF;
      st_nxt.recall_needed = 1'b1;
      st_nxt.addr_src = '0;
      st_nxt.addr = DPS_DEFAULT_ADDR;
      st_nxt.nrdy = 1'b1;
      st_nxt.vlo = 1'b1;
      st_nxt.armed = 1'b0;
      st_nxt.txf = 1'b0;
      st_nxt.cnt = '0;
    end else begin
      case (st_r.state)
        DPS_OFF: begin
          st_nxt.nrdy = 1'b1;
          if (ana_good) begin
            st_nxt.state = st_r.recall_needed ? DPS_RECALL : DPS_RUN;
            st_nxt.cnt = '0;
          end
        end
        DPS_RECALL: begin
          if (!nrdy_due(st_r.cnt)) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
          end
          if (!ana_good) begin
            st_nxt.state = DPS_OFF;
          end else if (i_recall_done) begin
            st_nxt.addr_src = i_nv_addr_src;
            st_nxt.addr = i_nv_addr_src[DPS_ADDR_FROM_NV_BIT] ?
              i_nv_addr : DPS_DEFAULT_ADDR;
            st_nxt.recall_needed = 1'b0;
            st_nxt.state = DPS_RUN;
          end
        end
        DPS_RUN: begin
          if (!ana_good) begin
            st_nxt.state = DPS_HOLD;
            st_nxt.nrdy = 1'b1;
            st_nxt.vlo = 1'b1;
            st_nxt.armed = 1'b0;
            st_nxt.cnt = '0;
          end else if (st_r.nrdy) begin
            if (nrdy_due(st_r.cnt)) begin
              st_nxt.nrdy = 1'b0;
            end else begin
              st_nxt.cnt = st_r.cnt + 1'b1;
            end
          end
        end
        DPS_HOLD: begin
          if (ana_good) begin
            st_nxt.state = DPS_RUN;
          end
        end
        default: st_nxt.state = DPS_OFF;
      endcase
      if (st_r.state != DPS_RUN || !ana_good) begin
        st_nxt.vlo = 1'b1;
      end else if (conv_above) begin
        st_nxt.vlo = 1'b0;
        st_nxt.armed = 1'b1;
      end
      if (st_r.armed && st_r.state == DPS_RUN) begin
        if (tx_fault) begin
          st_nxt.txf = 1'b1;
        end else if (i_clr_tx_fault) begin
          st_nxt.txf = 1'b0;
        end
      end else begin
        st_nxt.txf = 1'b0;
      end
      if (i_reg_wr && hit(i_reg_addr, DPS_ADDR_SRC_OFS) &&
          st_r.state == DPS_RUN) begin
        st_nxt.addr_src = i_reg_wdata;
      end
    end
    st_nxt.run = (st_nxt.state == DPS_RUN);
    st_nxt.rcl = (st_nxt.state == DPS_RECALL);
    if (hit(i_reg_addr, DPS_STATUS_OFS)) begin
      st_nxt.rdata = '0;
      st_nxt.rdata[DPS_NRDY_BIT] = st_nxt.nrdy;
      st_nxt.rdata[DPS_VLO_BIT] = st_nxt.vlo;
      st_nxt.rdata[DPS_TXF_BIT] = st_nxt.txf;
    end else if (hit(i_reg_addr, DPS_ADDR_SRC_OFS)) begin
      st_nxt.rdata = st_nxt.addr_src;
    end else begin
      st_nxt.rdata = '0;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_r.state <= DPS_OFF;
      st_r.recall_needed <= 1'b1;
      st_r.cnt <= '0;
      st_r.nrdy <= 1'b1;
      st_r.vlo <= 1'b1;
      st_r.armed <= 1'b0;
      st_r.txf <= 1'b0;
      st_r.run <= 1'b0;
      st_r.rcl <= 1'b0;
      st_r.addr_src <= '0;
      st_r.addr <= DPS_DEFAULT_ADDR;
      st_r.rdata <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign o_reg_rdata = st_r.rdata;
  assign o_recall_req = st_r.rcl;
  assign o_defaults = st_r.recall_needed;
  assign o_analog_en = st_r.run;
  assign o_out_en = st_r.run;
  assign o_not_ready_flag = st_r.nrdy;
  assign o_supply_low_alarm = st_r.vlo;
  assign o_tx_fault_output = st_r.txf;
  assign o_bus_addr = st_r.addr;
endmodule : dps_sequencer

// ---- verif/dps_chk.sv ----
// assertion checker for the power-on sequencer
`timescale 1ns/10ps
module dps_chk
  import dps_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_dig_good,
  input wire logic i_ana_good,
  input wire logic i_vcc_conv_valid,
  input wire logic [15:0] i_vcc_conv,
  input wire logic [15:0] i_vcc_low_limit,
  input wire logic o_recall_req,
  input wire logic o_defaults,
  input wire logic o_analog_en,
  input wire logic o_not_ready_flag,
  input wire logic o_supply_low_alarm,
  input wire logic [7:0] o_bus_addr
);
  localparam int NRDY_LIM = DPS_NRDY_CYC;
  int good_cnt;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !i_dig_good || !i_ana_good) begin
      good_cnt <= 0;
    end else if (i_ce) begin
      good_cnt <= good_cnt + 1;
    end
  end
  sequence s_low;
    !i_ana_good [*4];
  endsequence
  ana_off_a:
    assert property (s_low |-> !o_analog_en) else $error("analog on");
  alarm_set_a:
    assert property (s_low |-> o_supply_low_alarm) else $error("no alarm");
  nrdy_set_a:
    assert property (s_low |-> o_not_ready_flag) else $error("ready low");
  nrdy_clr_a:
    assert property (o_not_ready_flag |-> good_cnt < NRDY_LIM)
      else $error("ready late");
  recall_first_a:
    assert property ($rose(o_analog_en) && $past(o_defaults) |->
      $past(o_recall_req)) else $error("no recall");
  resume_a:
    assert property ((i_dig_good && i_ana_good && !o_defaults) [*4] |->
      o_analog_en && !o_recall_req) else $error("no resume");
  dig_drop_a:
    assert property ($fell(i_dig_good) |-> ##[1:4] o_defaults)
      else $error("no defaults");
  addr_def_a:
    assert property (o_recall_req |-> o_bus_addr == DPS_DEFAULT_ADDR)
      else $error("bad address");
  alarm_clr_a:
    assert property (o_analog_en && i_vcc_conv_valid &&
      i_vcc_conv > i_vcc_low_limit |-> ##[1:2] !o_supply_low_alarm)
      else $error("alarm stuck");
endmodule : dps_chk
bind dps_sequencer dps_chk u_chk (.i_clk, .i_rst_n, .i_ce, .i_dig_good,
  .i_ana_good, .i_vcc_conv_valid, .i_vcc_conv, .i_vcc_low_limit,
  .o_recall_req, .o_defaults, .o_analog_en, .o_not_ready_flag,
  .o_supply_low_alarm, .o_bus_addr);

// ---- verif/dps_host.sv ----
// serial host model reading and writing registers
`timescale 1ns/10ps
module dps_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic o_wr = 1'b0,
  output logic [7:0] o_addr = 8'h00,
  output logic [7:0] o_wdata = 8'h00
);
  // host polls only while above digital level
  task automatic xfer(input logic w, input logic [7:0] a, wd,
                      output logic [7:0] rd);
    @(negedge i_clk);
    o_wr = w;
    o_addr = a;
    o_wdata = wd;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~wd;
    rd = i_rdata;
  endtask : xfer
endmodule : dps_host

// ---- verif/tb_top.sv ----
// testbench for the power-on sequencer
`timescale 1ns/10ps
module tb_top;
  import dps_pkg::*;
  logic i_clk = 0, i_rst_n = 0, dig = 0, ana = 0, cv = 0, fin = 0, clr = 0;
  logic rdn = 0, ce = 1, wr, rq, dflt, aen, oen, nrdy, alm, txf;
  logic m_rq = 0, m_def = 1, m_on = 0, m_nrdy = 1, m_alm = 1;
  logic [15:0] conv = 0, lim = 16'h8000;
  logic [7:0] nva, wa, wd, rdat, bus, r;
  logic [31:0] seed = 32'h9714;
  int errors = 0, num_checks = 0, cyc = 0;
  always #12.5 i_clk = ~i_clk;
  dps_host u_host (.i_clk, .i_rdata(rdat), .o_wr(wr), .o_addr(wa),
    .o_wdata(wd));
  dps_sequencer dut (.i_clk, .i_rst_n, .i_ce(ce), .i_dig_good(dig),
    .i_ana_good(ana), .i_vcc_conv_valid(cv), .i_vcc_conv(conv),
    .i_vcc_low_limit(lim), .i_tx_fault_in(fin), .i_clr_tx_fault(clr),
    .i_nv_addr_src(8'h01), .i_nv_addr(nva), .i_recall_done(rdn),
    .i_reg_wr(wr), .i_reg_addr(wa), .i_reg_wdata(wd), .o_reg_rdata(rdat),
    .o_recall_req(rq), .o_defaults(dflt), .o_analog_en(aen), .o_out_en(oen),
    .o_not_ready_flag(nrdy), .o_supply_low_alarm(alm),
    .o_tx_fault_output(txf), .o_bus_addr(bus));
  task automatic chk(input string n, input logic [15:0] e, g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    xs = v ^ (v << 5);
  endfunction : xs
  task automatic st;
    chk("flags", {m_rq, m_def, m_on, m_on, m_nrdy, m_alm},
      {rq, dflt, aen, oen, nrdy, alm});
  endtask : st
  task automatic pwr(input logic d, a);
    @(negedge i_clk);
    dig = d;
    ana = a;
    repeat (4) @(negedge i_clk);
  endtask : pwr
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 25000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    seed = xs(seed);
    nva = seed[15:8];
    repeat (6) @(negedge i_clk);
    i_rst_n = 1;
    repeat (5) @(negedge i_clk);
    st();
    ce = 0;
    pwr(1, 1);
    st();
    ce = 1;
    @(negedge i_clk);
    m_rq = 1;
    st();
    fin = 1;
    rdn = 1;
    @(negedge i_clk);
    rdn = 0;
    repeat (2) @(negedge i_clk);
    {m_rq, m_def, m_on} = 3'b001;
    st();
    chk("addr", nva, bus);
    chk("fault", 1'b0, txf);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      conv = (i == 5) ? 16'hFFFF : seed[15:0];
      cv = 1;
      @(negedge i_clk);
      cv = 0;
      if (conv > lim) m_alm = 0;
      repeat (3) @(negedge i_clk);
      chk("alarm", m_alm, alm);
      chk("fault", !m_alm, txf);
    end
    fin = 0;
    repeat (3) @(negedge i_clk);
    chk("fault", 1'b1, txf);
    clr = 1;
    @(negedge i_clk);
    clr = 0;
    chk("fault", 1'b0, txf);
    seed = xs(seed);
    u_host.xfer(1, DPS_ADDR_SRC_OFS, seed[7:0], r);
    u_host.xfer(0, DPS_ADDR_SRC_OFS, 8'h00, r);
    chk("src", seed[7:0], r);
    u_host.xfer(0, 8'h10, 8'h00, r);
    chk("unmapped", 8'h00, r);
    u_host.xfer(0, DPS_STATUS_OFS, 8'h00, r);
    chk("status", 8'h01, r);
    repeat (DPS_NRDY_CYC) @(negedge i_clk);
    m_nrdy = 0;
    st();
    pwr(1, 0);
    {m_on, m_nrdy, m_alm} = 3'b011;
    st();
    u_host.xfer(0, DPS_STATUS_OFS, 8'h00, r);
    chk("status", 8'h03, r);
    pwr(1, 1);
    m_on = 1;
    st();
    pwr(0, 0);
    {m_def, m_on} = 2'b10;
    st();
    chk("addr", DPS_DEFAULT_ADDR, bus);
    pwr(1, 1);
    m_rq = 1;
    st();
    end_of_test();
  end
endmodule : tb_top
